// ==== common/cos_pkg.sv ====
// Purpose: constants and carriers for the converter overload/status register slice
// Assumes: 50 MHz system clock, byte-wide register port behind the serial-bus engine
// Notes:   bit positions are within the owning register; timer counts are in clock cycles
// Function
// - bypass on and output current over limit: clear bypass, request high-impedance
// - bypass has effect only in forward direction, never in reverse mode
// - no max-time option: re-admit overload after 25/50 ms timer and current below low
// - one bit enables three-level overload, another enables overload; 1 enables
// - upper limit select: 0 gives 1.5x, 1 gives 2x the current limit
// - reverse undervoltage select: 0 is 80% of target, 1 fixed 3.3V, default 1
// - hot field 00/01/10 pick 37.7/34.2/31.25%, 11 disables check, default 01
// - cold bit: 0 picks 77.15% (default), 1 picks 80%
// - status bit 7 reports one-shot conversion finished; one-shot mode only
// - status bit 6 reads 1 while input current is being limited
// - status bit 5 reads 1 while input voltage is being regulated
// - status bit 3 reads 1 once the bus watchdog has expired
// - state field 000 idle, 011 CC, 100/101/110 CV; others reserved
// - writing 1 to register-reset restores defaults; bit reads back 0
package cos_pkg;
  localparam logic [7:0] A_PWR_CTRL = 8'h19;
  localparam logic [7:0] A_TEMP_THR = 8'h1B;
  localparam logic [7:0] A_TEMP_REG = 8'h1C;
  localparam logic [7:0] A_REV_TEMP = 8'h1D;
  localparam logic [7:0] A_BYP_OVLD = 8'h1E;
  localparam logic [7:0] A_STAT1    = 8'h21;

  localparam logic [7:0] RST_TEMP_THR = 8'h82;
  localparam logic [7:0] RST_TEMP_REG = 8'h00;
  localparam logic [7:0] RST_REV_TEMP = 8'h40;
  localparam logic [7:0] RST_BYP_OVLD = 8'h20;

  localparam logic [7:0] WM_TEMP_THR = 8'hC3;
  localparam logic [7:0] WM_TEMP_REG = 8'h01;
  localparam logic [7:0] WM_REV_TEMP = 8'hE0;
  localparam logic [7:0] WM_BYP_OVLD = 8'h7F;

  localparam int B_REG_RST   = 7;
  localparam int B_HOT_HI    = 7;
  localparam int B_HOT_LO    = 6;
  localparam int B_COLD      = 5;
  localparam int B_TOVLD     = 6;
  localparam int B_REV_UV    = 5;
  localparam int B_BYPASS    = 4;
  localparam int B_OVERLOAD_MAX_TIME_EN   = 3;
  localparam int B_THREE_LVL = 2;
  localparam int B_UPPER_SEL = 1;
  localparam int B_OVLD_EN   = 0;
  localparam logic [1:0] HOT_OFF = 2'h3;

  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned T_OVLD_S_MS  = 25;
  localparam int unsigned T_OVLD_L_MS  = 50;
  localparam int unsigned T_MAX_MS     = 100;
  localparam int unsigned OVLD_S_CYC   = T_OVLD_S_MS * (CLK_HZ / 1000);
  localparam int unsigned OVLD_L_CYC   = T_OVLD_L_MS * (CLK_HZ / 1000);
  localparam int unsigned MAX_CYC      = T_MAX_MS * (CLK_HZ / 1000);
  localparam int          CNT_W        = 23;

  typedef struct packed {
    logic       ovld_en;
    logic       three_lvl_en;
    logic       upper_x2;
    logic       overload_max_time_en;
    logic       tovld_long;
    logic       rev_uv_fixed;
    logic [1:0] hot_code;
    logic       hot_chk_en;
    logic       cold_80;
  } cos_cfg_t;

  typedef struct packed {
    logic       adc_start;
    logic       adc_done;
    logic       adc_oneshot;
    logic       iin_limiting;
    logic       vin_regulating;
    logic       wdog_expired;
    logic [2:0] conv_state;
  } cos_stat_in_t;

  typedef enum logic [1:0] {
    OV_IDLE = 2'b00,
    OV_TIME = 2'b01,
    OV_WAIT = 2'b11
  } cos_ov_t;
endpackage : cos_pkg

// ==== hw/cos_regs.sv ====
// Purpose: bypass/overload/reverse-temperature control registers and status register 1
// Assumes: register accesses arrive already decoded from the serial-bus engine
// Notes:   control outputs are registered from the next register values, so they change with the register contents
`timescale 1ns/10ps
module cos_regs
  import cos_pkg::*;
#(
  parameter int unsigned OVLD_SHORT_CYC = OVLD_S_CYC,
  parameter int unsigned OVLD_LONG_CYC  = OVLD_L_CYC,
  parameter int unsigned OVLD_MAX_CYC   = MAX_CYC
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_wr_en,
  input  wire logic         i_rd_en,
  input  wire logic [7:0]   i_addr,
  input  wire logic [7:0]   i_wdata,
  input  wire cos_stat_in_t i_stat,
  input  wire logic         i_reverse_mode,
  input  wire logic         i_out_over_limit,
  input  wire logic         i_ovld_event,
  input  wire logic         i_below_lower_limit,
  output logic [7:0]        o_rdata,
  output logic              o_rvalid,
  output cos_cfg_t          o_cfg,
  output logic              o_bypass_active,
  output logic              o_hiz_set,
  output logic              o_ovld_ready,
  output logic              o_ovld_active
);
  logic [7:0] thr_reg, treg_reg, rev_reg, byp_reg, stat_reg;
  logic [7:0] thr_next, treg_next, rev_next, byp_next, stat_next;
  logic       wdog_d_reg;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  cos_ov_t    ov_reg, ov_next;

  wire wr_thr  = i_wr_en && (i_addr == A_TEMP_THR);
  wire wr_treg = i_wr_en && (i_addr == A_TEMP_REG);
  wire wr_rev  = i_wr_en && (i_addr == A_REV_TEMP);
  wire wr_byp  = i_wr_en && (i_addr == A_BYP_OVLD);
  wire reg_rst = i_wr_en && (i_addr == A_PWR_CTRL) && i_wdata[B_REG_RST];

  // only writable bits take the bus value; the rest keep their reset value
  wire [7:0] thr_w  = (thr_reg & ~WM_TEMP_THR) | (i_wdata & WM_TEMP_THR);
  wire [7:0] treg_w = (treg_reg & ~WM_TEMP_REG) | (i_wdata & WM_TEMP_REG);
  wire [7:0] rev_w  = (rev_reg & ~WM_REV_TEMP) | (i_wdata & WM_REV_TEMP);
  wire [7:0] byp_w  = (byp_reg & ~WM_BYP_OVLD) | (i_wdata & WM_BYP_OVLD);

  wire fwd_bypass = byp_reg[B_BYPASS] && !i_reverse_mode;
  wire byp_trip   = fwd_bypass && i_out_over_limit;
  wire wdog_rise  = i_stat.wdog_expired && !wdog_d_reg;
  wire [7:0] byp_m = wr_byp ? byp_w : byp_reg;
  // hardware clear beats a same-cycle host write so a trip is never undone
  wire byp_clr    = byp_trip || wdog_rise;

  assign thr_next  = reg_rst ? RST_TEMP_THR : (wr_thr ? thr_w : thr_reg);
  assign treg_next = reg_rst ? RST_TEMP_REG : (wr_treg ? treg_w : treg_reg);
  assign rev_next  = reg_rst ? RST_REV_TEMP : (wr_rev ? rev_w : rev_reg);
  assign byp_next  = reg_rst ? RST_BYP_OVLD :
                     (byp_clr ? (byp_m & ~(8'h01 << B_BYPASS)) : byp_m);

  wire adc_fin   = i_stat.adc_done && i_stat.adc_oneshot;
  // a finish in the same cycle as a new start still reports done
  wire adc_bit   = adc_fin || (stat_reg[7] && !i_stat.adc_start && i_stat.adc_oneshot);
  wire st_rsv    = (i_stat.conv_state == 3'h1) || (i_stat.conv_state == 3'h2) ||
                   (i_stat.conv_state == 3'h7);
  wire [2:0] st_code = st_rsv ? 3'h0 : i_stat.conv_state;
  assign stat_next = {adc_bit,
                      i_stat.iin_limiting,
                      i_stat.vin_regulating,
                      1'b0,
                      i_stat.wdog_expired,
                      st_code};

  // overload re-arm timer
  wire [CNT_W-1:0] tovld_lim = byp_reg[B_TOVLD] ? CNT_W'(OVLD_LONG_CYC) :
                               CNT_W'(OVLD_SHORT_CYC);
  wire tovld_done = (cnt_reg >= tovld_lim - CNT_W'(1));
  wire overload_max_time_done  = byp_reg[B_OVERLOAD_MAX_TIME_EN] && (cnt_reg >= CNT_W'(OVLD_MAX_CYC) - CNT_W'(1));
  wire ov_on      = byp_reg[B_OVLD_EN];

  always_comb begin
    ov_next  = ov_reg;
    cnt_next = cnt_reg;
    unique case (ov_reg)
      OV_IDLE: begin
        cnt_next = '0;
        if (ov_on && i_ovld_event) begin
          ov_next = OV_TIME;
        end
      end
      OV_TIME: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (overload_max_time_done) begin
          ov_next = OV_IDLE;
        end else if (tovld_done) begin
          // max time only adds an exit; the low-current exit stays available
          ov_next = OV_WAIT;
        end
      end
      OV_WAIT: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (i_below_lower_limit || overload_max_time_done) begin
          ov_next = OV_IDLE;
        end
      end
      default: begin
        ov_next  = OV_IDLE;
        cnt_next = '0;
      end
    endcase
    if (!ov_on) begin
      ov_next  = OV_IDLE;
      cnt_next = '0;
    end
  end

  wire hot_off = (rev_next[B_HOT_HI:B_HOT_LO] == HOT_OFF);
  cos_cfg_t cfg_next;
  assign cfg_next = '{ovld_en:      byp_next[B_OVLD_EN],
                      three_lvl_en: byp_next[B_THREE_LVL],
                      upper_x2:     byp_next[B_UPPER_SEL],
                      overload_max_time_en:      byp_next[B_OVERLOAD_MAX_TIME_EN],
                      tovld_long:   byp_next[B_TOVLD],
                      rev_uv_fixed: byp_next[B_REV_UV],
                      hot_code:     rev_next[B_HOT_HI:B_HOT_LO],
                      hot_chk_en:   !hot_off,
                      cold_80:      rev_next[B_COLD]};

  wire [7:0] rd_mux = (i_addr == A_TEMP_THR) ? thr_reg  :
                      (i_addr == A_TEMP_REG) ? treg_reg :
                      (i_addr == A_REV_TEMP) ? rev_reg  :
                      (i_addr == A_BYP_OVLD) ? byp_reg  :
                      (i_addr == A_STAT1)    ? stat_reg : 8'h00;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      thr_reg    <= RST_TEMP_THR;
      treg_reg   <= RST_TEMP_REG;
      rev_reg    <= RST_REV_TEMP;
      byp_reg    <= RST_BYP_OVLD;
      stat_reg   <= 8'h00;
      wdog_d_reg <= 1'b0;
    end else begin
      thr_reg    <= thr_next;
      treg_reg   <= treg_next;
      rev_reg    <= rev_next;
      byp_reg    <= byp_next;
      stat_reg   <= stat_next;
      wdog_d_reg <= i_stat.wdog_expired;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ov_reg  <= OV_IDLE;
      cnt_reg <= '0;
    end else begin
      ov_reg  <= ov_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata         <= 8'h00;
      o_rvalid        <= 1'b0;
      o_cfg           <= '0;
      o_bypass_active <= 1'b0;
      o_hiz_set       <= 1'b0;
      o_ovld_ready    <= 1'b0;
      o_ovld_active   <= 1'b0;
    end else begin
      o_rdata         <= i_rd_en ? rd_mux : o_rdata;
      o_rvalid        <= i_rd_en;
      o_cfg           <= cfg_next;
      o_bypass_active <= byp_next[B_BYPASS] && !i_reverse_mode;
      o_hiz_set       <= byp_trip;
      o_ovld_ready    <= ov_on && (ov_next == OV_IDLE);
      o_ovld_active   <= ov_next != OV_IDLE;
    end
  end

  sequence s_trip;
    byp_reg[B_BYPASS] && !i_reverse_mode && i_out_over_limit;
  endsequence
  sequence s_tovld_end;
    ov_reg == OV_TIME && tovld_done && !overload_max_time_done && ov_on;
  endsequence

  a_bypass_trip: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_trip |=> !byp_reg[B_BYPASS] && o_hiz_set)
    else $error("bypass not cleared on overcurrent");
  a_bypass_reverse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_reverse_mode |=> !o_bypass_active)
    else $error("bypass active in reverse mode");
  a_tovld_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_tovld_end |=> ov_reg == OV_WAIT ##0 !o_ovld_ready)
    else $error("overload timer end mishandled");
  a_overload_max_time_rearm: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    overload_max_time_done && ov_reg != OV_IDLE && ov_on |=> ov_reg == OV_IDLE && o_ovld_ready)
    else $error("max time did not re-admit overload");
  a_hot_disable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    rev_next[B_HOT_HI:B_HOT_LO] == HOT_OFF |=> !o_cfg.hot_chk_en)
    else $error("hot check not disabled");
  a_adc_done_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_stat.adc_done && i_stat.adc_oneshot |=> stat_reg[7])
    else $error("conversion done not reported");
  a_state_rsv: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    st_rsv |=> stat_reg[2:0] == 3'h0)
    else $error("reserved converter state shown");
  a_reg_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    reg_rst |=> byp_reg == RST_BYP_OVLD && rev_reg == RST_REV_TEMP && thr_reg == RST_TEMP_THR)
    else $error("register reset did not restore defaults");
  a_ro_ignored: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_rev && !reg_rst |=> rev_reg[4:0] == 5'h00 && !byp_reg[7])
    else $error("reserved bits written");

  // overload window steps
  sequence s_ovld_take;
    ov_reg == OV_IDLE && ov_on && i_ovld_event;
  endsequence
  sequence s_wait_low;
    ov_reg == OV_WAIT && ov_on && i_below_lower_limit;
  endsequence
  sequence s_wait_hold;
    ov_reg == OV_WAIT && ov_on && !i_below_lower_limit && !overload_max_time_done;
  endsequence

  a_hiz_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !byp_trip |=> !o_hiz_set)
    else $error("high-impedance request without a trip");
  a_trip_wins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    byp_trip && wr_byp |=> !byp_reg[B_BYPASS])
    else $error("host write undid a bypass trip");
  a_trip_reverse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_reverse_mode |=> !o_hiz_set)
    else $error("bypass trip taken in reverse mode");
  a_ovld_take: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_ovld_take |=> ov_reg == OV_TIME && o_ovld_active && !o_ovld_ready && cnt_reg == '0)
    else $error("overload event not taken");
  a_time_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ov_reg == OV_TIME && ov_on && !tovld_done && !overload_max_time_done
    |=> ov_reg == OV_TIME && o_ovld_active)
    else $error("overload timer left early");
  a_wait_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_wait_hold |=> ov_reg == OV_WAIT && !o_ovld_ready)
    else $error("overload re-admitted before current fell");
  a_wait_exit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_wait_low |=> ov_reg == OV_IDLE && o_ovld_ready && !o_ovld_active)
    else $error("overload not re-admitted after current fell");
  a_timer_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ov_reg != OV_IDLE && ov_on |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("overload timer did not advance");
  a_tovld_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.tovld_long == $past(i_wdata[B_TOVLD]))
    else $error("timer select not applied");
  a_overload_max_time_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.overload_max_time_en == $past(i_wdata[B_OVERLOAD_MAX_TIME_EN]))
    else $error("max-time option not applied");
  a_ovld_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !ov_on |=> ov_reg == OV_IDLE && !o_ovld_ready && !o_ovld_active)
    else $error("overload active while disabled");
  a_ovld_enable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.ovld_en == $past(i_wdata[B_OVLD_EN]))
    else $error("overload enable not applied");
  a_three_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.three_lvl_en == $past(i_wdata[B_THREE_LVL]))
    else $error("three-level enable not applied");
  a_upper_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.upper_x2 == $past(i_wdata[B_UPPER_SEL]))
    else $error("upper limit select not applied");
  a_rev_uv_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_byp |=> o_cfg.rev_uv_fixed == $past(i_wdata[B_REV_UV]))
    else $error("reverse undervoltage select not applied");
  a_hot_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_rev |=> o_cfg.hot_code == $past(i_wdata[B_HOT_HI:B_HOT_LO]))
    else $error("hot threshold code not applied");
  a_cold_select: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_rev |=> o_cfg.cold_80 == $past(i_wdata[B_COLD]))
    else $error("cold threshold select not applied");
  a_adc_start_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_stat.adc_start && !i_stat.adc_done |=> !stat_reg[7])
    else $error("conversion done kept over a new start");
  a_adc_mode_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_stat.adc_oneshot |=> !stat_reg[7])
    else $error("conversion done shown outside one-shot mode");
  a_iin_status: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> stat_reg[6] == $past(i_stat.iin_limiting))
    else $error("input current status wrong");
  a_vin_status: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> stat_reg[5] == $past(i_stat.vin_regulating))
    else $error("input voltage status wrong");
  a_wdog_status: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> stat_reg[3] == $past(i_stat.wdog_expired))
    else $error("watchdog status wrong");
  a_state_pass: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !st_rsv |=> stat_reg[2:0] == $past(i_stat.conv_state))
    else $error("converter state not reported");
  a_ro_reserved: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !stat_reg[4] && thr_reg[5:2] == 4'h0 && treg_reg[7:1] == 7'h00)
    else $error("reserved field not at reset value");
  a_reset_rest: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    reg_rst |=> treg_reg == RST_TEMP_REG && !o_cfg.ovld_en && o_cfg.rev_uv_fixed)
    else $error("register reset left a field changed");
  a_reset_bypass: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    reg_rst |=> !o_bypass_active && o_cfg.hot_code == RST_REV_TEMP[B_HOT_HI:B_HOT_LO])
    else $error("register reset did not restore controls");
  a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_rd_en |=> !o_rvalid && o_rdata == $past(o_rdata))
    else $error("read data changed without a read");
endmodule : cos_regs

// ==== verif/cos_host_model.sv ====
// Purpose: host side of the decoded register port
// Assumes: one access per call, strobe held to its taking edge
// Notes:   write data is inverted once released so stale bytes never look valid
`timescale 1ns/10ps
module cos_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_sys_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_sys_clk);
    o_rd_en <= 1'b0;
    n = 0;
    #1;
    while (i_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    @(posedge i_sys_clk);
  endtask : rd
endmodule : cos_host_model

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the overload/status register slice
// Assumes: shortened overload timers 20/40/80 cycles
// Notes:   timer counts are checked inside a small window, not to the cycle
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import cos_pkg::*;
  logic         i_sys_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         wr_en, rd_en, rvalid, byp, hiz, rdy, act;
  logic [7:0]   addr, wdata, rdata;
  cos_stat_in_t i_stat = '0;
  logic         rev = 1'b0, over = 1'b0, ev = 1'b0, low = 1'b0;
  cos_cfg_t     cfg;
  int           fails = 0, check_count = 0, cyc = 0, n;
  logic [7:0]   ad [4] = '{A_TEMP_THR, A_TEMP_REG, A_REV_TEMP, A_BYP_OVLD};
  logic [7:0]   rs [4] = '{RST_TEMP_THR, RST_TEMP_REG, RST_REV_TEMP, RST_BYP_OVLD};
  logic [7:0]   wm [4] = '{WM_TEMP_THR, WM_TEMP_REG, WM_REV_TEMP, WM_BYP_OVLD};
  always #10 i_sys_clk = ~i_sys_clk;
  cos_host_model u_host (.i_sys_clk(i_sys_clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  cos_regs #(.OVLD_SHORT_CYC(20), .OVLD_LONG_CYC(40), .OVLD_MAX_CYC(80)) i_cos_regs (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .i_stat(i_stat), .i_reverse_mode(rev),
    .i_out_over_limit(over), .i_ovld_event(ev), .i_below_lower_limit(low),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg), .o_bypass_active(byp),
    .o_hiz_set(hiz), .o_ovld_ready(rdy), .o_ovld_active(act));
  task automatic give_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    `CHK("reg", e, v)
  endtask : rchk
  task automatic st(input logic [8:0] v, input logic [7:0] e);
    i_stat <= v;
    repeat (2) @(posedge i_sys_clk);
    rchk(A_STAT1, e);
  endtask : st
  // time from the event until a new one is admitted
  task automatic ovt(input logic [7:0] c, input logic lo, input int mn, input int mx);
    int k;
    u_host.wr(A_BYP_OVLD, c);
    repeat (3) @(posedge i_sys_clk);
    `CHK("ready", 1'b1, rdy)
    `CHK("ovld_en", 1'b1, cfg.ovld_en)
    `CHK("tovld", c[B_TOVLD], cfg.tovld_long)
    `CHK("overload_max_time", c[B_OVERLOAD_MAX_TIME_EN], cfg.overload_max_time_en)
    low <= lo;
    ev  <= 1'b1;
    @(posedge i_sys_clk);
    ev <= 1'b0;
    k = 0;
    #1;
    `CHK("active", 1'b1, act)
    while (rdy !== 1'b1 && k < 300) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    `CHK("ovl_time", 1'b1, (k >= mn && k <= mx))
  endtask : ovt
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 4; i++) rchk(ad[i], rs[i]);
    rchk(A_STAT1, 8'h00);
    rchk(8'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(ad[i], 8'hFF);
      rchk(ad[i], wm[i]);
    end
    repeat (2) @(posedge i_sys_clk);
    `CHK("hot", 2'h3, cfg.hot_code)
    `CHK("hot_en", 1'b0, cfg.hot_chk_en)
    `CHK("cold", 1'b1, cfg.cold_80)
    `CHK("upper", 1'b1, cfg.upper_x2)
    `CHK("three", 1'b1, cfg.three_lvl_en)
    u_host.wr(A_PWR_CTRL, 8'h80);
    rchk(A_PWR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) rchk(ad[i], rs[i]);
    `CHK("uv", 1'b1, cfg.rev_uv_fixed)
    `CHK("hot_rst", 2'h1, cfg.hot_code)
    u_host.wr(A_BYP_OVLD, 8'h10);
    rev <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    `CHK("byp_rev", 1'b0, byp)
    rev <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    `CHK("byp_fwd", 1'b1, byp)
    over <= 1'b1;
    n = 0;
    repeat (5) begin
      @(posedge i_sys_clk);
      #1;
      if (hiz === 1'b1) n++;
    end
    @(posedge i_sys_clk);
    over <= 1'b0;
    `CHK("hiz", 1, n)
    `CHK("byp_trip", 1'b0, byp)
    rchk(A_BYP_OVLD, 8'h00);
    ovt(8'h01, 1'b1, 18, 26);
    ovt(8'h41, 1'b1, 38, 46);
    ovt(8'h09, 1'b0, 78, 86);
    ovt(8'h09, 1'b1, 18, 26);
    ovt(8'h01, 1'b0, 300, 300);
    @(posedge i_sys_clk);
    low <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    `CHK("ready_low", 1'b1, rdy)
    u_host.wr(A_STAT1, 8'hFF);
    st(9'h03B, 8'h6B);
    st(9'h015, 8'h25);
    st(9'h007, 8'h00);
    st(9'h040, 8'h00);
    i_stat <= 9'h0C0;
    @(posedge i_sys_clk);
    st(9'h040, 8'h80);
    i_stat <= 9'h140;
    @(posedge i_sys_clk);
    st(9'h040, 8'h00);
    give_verdict();
  end
endmodule : testbench
